// ==== verilog/rdm_defs.svh ====
// device-space constants for the remote i/o device mapper
`ifndef RDM_DEFS_SVH
`define RDM_DEFS_SVH
`define RDM_STRIDE        12'h020
`define RDM_HALF_SPAN     12'h010
`define RDM_MAIN_X_BASE   12'h000
`define RDM_MAIN_X_END    12'h0ff
`define RDM_MAIN_Y_BASE   12'h000
`define RDM_MAIN_Y_END    12'h0ff
`define RDM_P1_BASE       12'h100
`define RDM_P1_END        12'h13f
`define RDM_P1_RESET_X    12'h108
`define RDM_P2_X_BASE     12'h640
`define RDM_P2_X_END      12'h73f
`define RDM_P2_Y_BASE     12'h740
`define RDM_P2_Y_END      12'h83f
`define RDM_P1_RIN_BASE   12'h050
`define RDM_P1_RIN_END    12'h053
`define RDM_P1_ROUT_BASE  12'h0b4
`define RDM_P1_ROUT_END   12'h0b7
`define RDM_AO_BASE       12'h064
`define RDM_AO_END        12'h067
`define RDM_MAX_POINTS    4'h8
`define RDM_P1_MAX_SW     3'h3
`endif

// ==== verilog/rdm_pkg.sv ====
// types shared by the remote i/o device mapper
package rdm_pkg;
  typedef enum logic [1:0] {
    RDM_SP_X = 2'h0,
    RDM_SP_Y = 2'h1,
    RDM_SP_R = 2'h3
  } rdm_space_e;

  typedef struct packed {
    rdm_space_e  space;
    logic [11:0] addr;
  } rdm_req_s;

  typedef struct packed {
    logic       hit;
    logic       reserved;
    logic       opBoard;
    logic [2:0] station;
    logic [4:0] bitIdx;
    logic       isWord;
    logic       wordIdx;
    logic       isOutput;
    logic       isAo;
  } rdm_resp_s;
endpackage

// ==== verilog/rdm_ao_rank.sv ====
// ascending switch-order rank of stations that carry an analog output
module rdm_ao_rank
  import rdm_pkg::*;
(
  input  wire logic [7:0]      aoMask,
  output logic      [7:0][2:0] rank,
  output logic      [3:0]      aoCount
);
  always_comb begin
    logic [3:0] acc;
    acc = 4'h0;
    for (int i = 0; i < 8; i++) begin
      rank[i] = acc[2:0];
      if (aoMask[i]) begin
        acc = acc + 4'h1;
      end
    end
    aoCount = acc;
  end
endmodule

// ==== verilog/rdm_mapper.sv ====
// remote i/o station to controller device-space mapper
`include "rdm_defs.svh"

module rdm_mapper
  import rdm_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      patternTwo,
  input  wire logic [7:0] mainPresent,
  input  wire logic [7:0] mainTwoPoint,
  input  wire logic [7:0] mainHalfOut,
  input  wire logic [7:0] mainHasAo,
  input  wire logic [7:0] opPresent,
  input  wire logic      reqValid,
  input  wire rdm_req_s  req,
  output logic           respValid,
  output rdm_resp_s      resp,
  output logic [7:0][2:0] aoSlot,
  output logic [7:0]     aoSlotValid,
  output logic           cfgError
);
  // ***************************************
  // configuration synchronisers
  // ***************************************
  // strap-like pins from outside: two flops before any use
  localparam int CW = 41;
  logic [CW-1:0] cfgMeta_q, cfgSync_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgMeta_q <= '0;
      cfgSync_q <= '0;
    end else begin
      cfgMeta_q <= {patternTwo, mainPresent, mainTwoPoint, mainHalfOut, mainHasAo, opPresent};
      cfgSync_q <= cfgMeta_q;
    end
  end

  logic       patTwo;
  logic [7:0] mPres, mTwo, mHalf, mAo, oPres;
  assign {patTwo, mPres, mTwo, mHalf, mAo, oPres} = cfgSync_q;

  // ***************************************
  // helpers
  // ***************************************
  function automatic logic inRange(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [7:0] offsetOf(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[7:0];
  endfunction

  // ***************************************
  // analog output ranking
  // ***************************************
  logic [7:0][2:0] rank;
  logic [3:0]      aoCount;

  rdm_ao_rank u_rank (
    .aoMask  (mPres & mAo),
    .rank    (rank),
    .aoCount (aoCount)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aoSlot      <= '0;
      aoSlotValid <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        aoSlot[i]      <= rank[i];
        aoSlotValid[i] <= mPres[i] && mAo[i] && (rank[i] < 3'h4);
      end
    end
  end

  // ***************************************
  // configuration checks
  // ***************************************
  logic cfgError_d;
  always_comb begin
    logic [4:0] pts;
    logic       clash;
    pts   = 5'h00;
    clash = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (mPres[i]) begin
        pts = pts + (mTwo[i] ? 5'h02 : 5'h01);
      end
      if (mPres[i] && mTwo[i]) begin
        if (i == 7) begin
          clash = 1'b1;
        end else if (mPres[3'(i + 1)]) begin
          clash = 1'b1;
        end
      end
    end
    cfgError_d = (pts > {1'b0, `RDM_MAX_POINTS})
               || clash
               || (aoCount > 4'h4)
               || (!patTwo && (oPres[7:4] != 4'h0));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgError <= 1'b0;
    end else begin
      cfgError <= cfgError_d;
    end
  end

  // ***************************************
  // address lookup
  // ***************************************
  rdm_resp_s resp_d;
  always_comb begin
    logic [7:0] off;
    resp_d = '0;
    off    = 8'h00;
    unique case (req.space)
      RDM_SP_X: begin
        if (inRange(req.addr, `RDM_MAIN_X_BASE, `RDM_MAIN_X_END)) begin
          off            = offsetOf(req.addr, `RDM_MAIN_X_BASE);
          resp_d.station = off[7:5];
          resp_d.bitIdx  = off[4:0];
          resp_d.hit     = mPres[off[7:5]];
        end else if (!patTwo && req.addr == `RDM_P1_RESET_X) begin
          resp_d.reserved = 1'b1;
          resp_d.opBoard  = 1'b1;
        end else if (!patTwo && inRange(req.addr, `RDM_P1_BASE, `RDM_P1_END)) begin
          off            = offsetOf(req.addr, `RDM_P1_BASE);
          resp_d.opBoard = 1'b1;
          resp_d.station = {2'b00, off[5]};
          resp_d.bitIdx  = off[4:0];
          resp_d.hit     = oPres[off[5]];
        end else if (patTwo && inRange(req.addr, `RDM_P2_X_BASE, `RDM_P2_X_END)) begin
          off            = offsetOf(req.addr, `RDM_P2_X_BASE);
          resp_d.opBoard = 1'b1;
          resp_d.station = off[7:5];
          resp_d.bitIdx  = off[4:0];
          resp_d.hit     = oPres[off[7:5]];
        end
      end
      RDM_SP_Y: begin
        resp_d.isOutput = 1'b1;
        if (inRange(req.addr, `RDM_MAIN_Y_BASE, `RDM_MAIN_Y_END)) begin
          off            = offsetOf(req.addr, `RDM_MAIN_Y_BASE);
          resp_d.station = off[7:5];
          resp_d.bitIdx  = off[4:0];
          // 16-output right card leaves the upper half unmapped
          resp_d.hit     = mPres[off[7:5]] && !(mHalf[off[7:5]] && off[4]);
        end else if (!patTwo && inRange(req.addr, `RDM_P1_BASE, `RDM_P1_END)) begin
          off            = offsetOf(req.addr, `RDM_P1_BASE);
          resp_d.opBoard = 1'b1;
          resp_d.station = {2'b00, off[5]};
          resp_d.bitIdx  = off[4:0];
          resp_d.hit     = oPres[off[5]];
        end else if (patTwo && inRange(req.addr, `RDM_P2_Y_BASE, `RDM_P2_Y_END)) begin
          off            = offsetOf(req.addr, `RDM_P2_Y_BASE);
          resp_d.opBoard = 1'b1;
          resp_d.station = off[7:5];
          resp_d.bitIdx  = off[4:0];
          resp_d.hit     = oPres[off[7:5]];
        end
      end
      RDM_SP_R: begin
        resp_d.isWord = 1'b1;
        if (!patTwo && inRange(req.addr, `RDM_P1_RIN_BASE, `RDM_P1_RIN_END)) begin
          off            = offsetOf(req.addr, `RDM_P1_RIN_BASE);
          resp_d.opBoard = 1'b1;
          resp_d.station = {2'b01, off[1]};
          resp_d.wordIdx = off[0];
          resp_d.hit     = oPres[{2'b01, off[1]}];
        end else if (!patTwo && inRange(req.addr, `RDM_P1_ROUT_BASE, `RDM_P1_ROUT_END)) begin
          off             = offsetOf(req.addr, `RDM_P1_ROUT_BASE);
          resp_d.opBoard  = 1'b1;
          resp_d.isOutput = 1'b1;
          resp_d.station  = {2'b01, off[1]};
          resp_d.wordIdx  = off[0];
          resp_d.hit      = oPres[{2'b01, off[1]}];
        end else if (inRange(req.addr, `RDM_AO_BASE, `RDM_AO_END)) begin
          off             = offsetOf(req.addr, `RDM_AO_BASE);
          resp_d.isOutput = 1'b1;
          resp_d.isAo     = 1'b1;
          // only main-channel stations take an analog word
          for (int i = 7; i >= 0; i--) begin
            if (mPres[i] && mAo[i] && rank[i] == {1'b0, off[1:0]}) begin
              resp_d.station = 3'(i);
              resp_d.hit     = 1'b1;
            end
          end
        end
      end
      default: begin
        resp_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      respValid <= 1'b0;
      resp      <= '0;
    end else begin
      respValid <= reqValid;
      resp      <= reqValid ? resp_d : '0;
    end
  end
endmodule

// ==== tb/rdm_mapper_properties.sv ====
// assertions on the remote i/o mapper ports
module rdm_mapper_properties
  import rdm_pkg::*;
(
  input logic       clk,
  input logic       rst_n,
  input logic       patternTwo,
  input logic [7:0] opPresent,
  input logic       reqValid,
  input rdm_req_s   req,
  input logic       respValid,
  input rdm_resp_s  resp,
  input logic       cfgError
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic xq;
  logic yq;
  assign xq = reqValid && req.space == RDM_SP_X;
  assign yq = reqValid && req.space == RDM_SP_Y;
  property p_x_main;
    xq && req.addr < 12'h100 |=> respValid && !resp.opBoard && resp.station == $past(req.addr[7:5]);
  endproperty
  a_x_main: assert property (p_x_main) else $error("main input misplaced");
  property p_y_main;
    yq && req.addr < 12'h100 |=> resp.isOutput && resp.bitIdx == $past(req.addr[4:0]);
  endproperty
  a_y_main: assert property (p_y_main) else $error("main output misplaced");
  property p_ao_word;
    reqValid && req.space == RDM_SP_R && req.addr[11:2] == 10'h019
      |=> respValid && resp.isWord && resp.isAo && !resp.opBoard;
  endproperty
  a_ao_word: assert property (p_ao_word) else $error("analog word misread");
  // pattern held four edges so the two-flop sync has settled
  property p_p1_bits;
    !patternTwo [*4] ##0 (xq && req.addr[11:6] == 6'h04 && req.addr != 12'h108)
      |=> resp.opBoard && resp.station == $past(req.addr[7:5]);
  endproperty
  a_p1_bits: assert property (p_p1_bits) else $error("op board bit misplaced");
  property p_p1_rsvd;
    !patternTwo [*4] ##0 (xq && req.addr == 12'h108) |=> resp.reserved && !resp.hit;
  endproperty
  a_p1_rsvd: assert property (p_p1_rsvd) else $error("reset bit not held back");
  property p_p2_map;
    patternTwo [*4] ##0 (xq && req.addr >= 12'h640 && req.addr < 12'h740)
      |=> resp.opBoard && resp.station == $past(req.addr[7:5]) - 3'h2;
  endproperty
  a_p2_map: assert property (p_p2_map) else $error("second pattern misplaced");
  property p_op_noao;
    respValid && resp.opBoard |-> !resp.isAo;
  endproperty
  a_op_noao: assert property (p_op_noao) else $error("op board analog");
  property p_p1_limit;
    (!patternTwo && opPresent[7:4] != 4'h0) [*4] |-> cfgError;
  endproperty
  a_p1_limit: assert property (p_p1_limit) else $error("op station limit");
endmodule

// ==== tb/rdm_station_model.sv ====
// station population presets standing in for the remote i/o stations
module rdm_station_model (
  input  logic [1:0] setup,
  output logic [7:0] present,
  output logic [7:0] twoPoint,
  output logic [7:0] halfOut,
  output logic [7:0] hasAo,
  output logic [7:0] opStations
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    case (setup)
      2'h0: {present, twoPoint, halfOut, hasAo, opStations} = 40'hff_00_08_00_00;
      2'h1: {present, twoPoint, halfOut, hasAo, opStations} = 40'h55_55_00_50_0f;
      // overload on purpose: nine points and op switches above 3
      2'h2: {present, twoPoint, halfOut, hasAo, opStations} = 40'hff_01_00_00_f0;
      default: {present, twoPoint, halfOut, hasAo, opStations} = 40'h00_00_00_00_ff;
    endcase
  end
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the remote i/o device mapper
module tb_top
  import rdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            patternTwo = 1'b0;
  logic            reqValid = 1'b0;
  rdm_req_s        req = '0;
  logic [1:0]      setup = 2'h0;
  logic [7:0]      pres, two, half, ao, op, aoSlotValid;
  logic            respValid, cfgError;
  rdm_resp_s       resp, r;
  logic [7:0][2:0] aoSlot;
  int              bad_count = 0;
  int              checked = 0;
  rdm_station_model rdm_station_model_i (.setup(setup), .present(pres), .twoPoint(two), .halfOut(half),
    .hasAo(ao), .opStations(op));
  rdm_mapper rdm_mapper_i (.clk(clk), .rst_n(rst_n), .patternTwo(patternTwo), .mainPresent(pres),
    .mainTwoPoint(two), .mainHalfOut(half), .mainHasAo(ao), .opPresent(op), .reqValid(reqValid),
    .req(req), .respValid(respValid), .resp(resp), .aoSlot(aoSlot), .aoSlotValid(aoSlotValid),
    .cfgError(cfgError));
  task automatic chk(input bit ok);
    checked++;
    if (!ok) begin
      bad_count++;
      $display("ERROR at %0t: unexpected answer", $time);
    end
  endtask
  task automatic look(input rdm_space_e sp, input logic [11:0] a);
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{space: sp, addr: a};
    @(posedge clk);
    reqValid <= 1'b0;
    #1 r = resp;
    chk(respValid === 1'b1);
  endtask
  // wait out the two-flop sync plus the output register
  task automatic setcfg(input logic [1:0] s, input logic p);
    @(posedge clk);
    setup <= s;
    patternTwo <= p;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_main();
    setcfg(2'h0, 1'b0);
    for (int n = 0; n < 8; n++) begin
      look(RDM_SP_X, 12'(n * 32 + 31));
      chk(r.hit === 1'b1 && r.station === 3'(n) && r.bitIdx === 5'h1f);
      look(RDM_SP_Y, 12'(n * 32 + 16));
      chk(r.hit === (n != 3) && r.isOutput === 1'b1);
    end
    $display("main channel done");
  endtask
  task automatic t_ao();
    setcfg(2'h1, 1'b0);
    chk(aoSlotValid === 8'h50 && aoSlot[4] === 3'h0 && aoSlot[6] === 3'h1);
    look(RDM_SP_R, 12'h065);
    chk(r.hit === 1'b1 && r.isAo === 1'b1 && r.station === 3'h6);
    chk(cfgError === 1'b0);
    look(RDM_SP_X, 12'h125);
    chk(r.hit === 1'b1 && r.opBoard === 1'b1 && r.station === 3'h1 && r.bitIdx === 5'h05);
    look(RDM_SP_Y, 12'h13f);
    chk(r.hit === 1'b1 && r.opBoard === 1'b1 && r.isOutput === 1'b1 && r.station === 3'h1);
    look(RDM_SP_X, 12'h108);
    chk(r.reserved === 1'b1 && r.hit === 1'b0);
    look(RDM_SP_R, 12'h052);
    chk(r.isWord === 1'b1 && r.station === 3'h3 && r.wordIdx === 1'b0 && r.isOutput === 1'b0);
    look(RDM_SP_R, 12'h0b5);
    chk(r.isWord === 1'b1 && r.station === 3'h2 && r.wordIdx === 1'b1 && r.isOutput === 1'b1);
    look(RDM_SP_X, 12'h640);
    chk(r.hit === 1'b0);
    $display("analog and pattern one done");
  endtask
  task automatic t_p2();
    setcfg(2'h3, 1'b1);
    for (int n = 0; n < 8; n++) begin
      look(RDM_SP_X, 12'(12'h640 + n * 32));
      chk(r.hit === 1'b1 && r.opBoard === 1'b1 && r.station === 3'(n));
      look(RDM_SP_Y, 12'(12'h740 + n * 32 + 31));
      chk(r.hit === 1'b1 && r.isOutput === 1'b1 && r.station === 3'(n) && r.isAo === 1'b0);
    end
    look(RDM_SP_X, 12'h108);
    chk(r.reserved === 1'b0);
    chk(cfgError === 1'b0);
    setcfg(2'h2, 1'b0);
    chk(cfgError === 1'b1);
    $display("pattern two and overload done");
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_main();
    t_ao();
    t_p2();
    report_and_stop();
  end
  // the run needs some 100 cycles, so this leaves ample margin
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule
bind rdm_mapper rdm_mapper_properties rdm_mapper_properties_i (.clk(clk), .rst_n(rst_n),
  .patternTwo(patternTwo), .opPresent(opPresent), .reqValid(reqValid), .req(req),
  .respValid(respValid), .resp(resp), .cfgError(cfgError));
